// file: rtl/omwc_mode_ctrl.v
// Function
// - Exactly three modes: normal, idle, stop
// - Reset release always lands in normal mode
// - Normal: both oscillators running, CPU clocked
// - Stop bit set enters stop, fast oscillator and all clocks stopped
// - Hardware clears stop bit on stop exit
// - Idle bit set stops CPU clock only
// - Hardware clears idle bit on idle exit
// - Idle keeps peripherals clocked, interrupts live
// - Stop gates peripherals and interrupts, analog stays
// - Slow RC runs in stop only if watchdog-always
// - Stop keeps all registers and state
// - Stop exits only on enabled wake-pin change
// - Idle exits on pin change or enabled interrupt
// - Pin wake on either edge
// - First port wake always enabled
// - Second port pin wakes when its bit set
// - Crystal stop wake waits 2048 fast plus 5 slow
// - RC stop wake waits 64 fast plus 5 slow
// - Every wake returns normal, flags kept
// - Power control: stop bit1, idle bit0, reset 8 (P2SEL set)
// - Interrupt needs global and source enable
//
// Chosen here: register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "omwc_regs.vh"

module omwc_mode_ctrl #(
  parameter integer IRQ_COUNT = 15,
  parameter integer XTAL_WAIT = `OMWC_XTAL_WAIT,
  parameter integer RC_WAIT   = `OMWC_RC_WAIT,
  parameter integer LRC_WAIT  = `OMWC_LRC_WAIT,
  parameter integer LRC_DIV   = `OMWC_SYS_CLK_HZ / `OMWC_LRC_HZ
) (
  input  wire                 sys_clk,
  input  wire                 reset,
  input  wire [11:0]          paddr,
  input  wire                 psel,
  input  wire                 penable,
  input  wire                 pwrite,
  input  wire [31:0]          pwdata,
  output reg  [31:0]          prdata,
  output wire                 pready,
  output wire                 pslverr,
  input  wire [7:0]           firstWakePort,
  input  wire [7:0]           secondWakePort,
  input  wire [IRQ_COUNT-1:0] irqFlags,
  input  wire [IRQ_COUNT-1:0] irqSourceEnable,
  output reg  [IRQ_COUNT-1:0] irqRequest,
  output reg                  fastOscEnable,
  output reg                  slowOscEnable,
  output reg                  cpuClockEnable,
  output reg                  periphClockEnable,
  output reg                  analogKeepEnable,
  output reg                  xramHighZero
);

  // Register state
  reg  [3:0]  powerCtl;
  reg  [7:0]  wakeEnable;
  reg  [2:0]  cfgBits;
  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg  [11:0] settleCount;
  reg  [11:0] next_settleCount;
  reg  [11:0] lrcDivCount;
  reg         lrcTick;
  reg  [1:0]  lastWake;
  reg  [7:0]  firstMeta;
  reg  [7:0]  firstSync;
  reg  [7:0]  firstPrev;
  reg  [7:0]  secondMeta;
  reg  [7:0]  secondSync;
  reg  [7:0]  secondPrev;

  wire        wrEn;
  wire        rdSetup;
  wire        addrHit;
  wire [7:0]  firstChange;
  wire [7:0]  secondChange;
  wire        pinWake;
  wire        irqWake;
  wire        globalIrqEnable;
  wire        oscIsCrystal;
  wire        watchdogAlways;
  wire        stopReq;
  wire        idleReq;
  wire [IRQ_COUNT-1:0] irqLive;
  reg         hwClearStop;
  reg         hwClearIdle;

  localparam [11:0] FAST_XTAL = XTAL_WAIT[11:0] - 12'h001;
  localparam [11:0] FAST_RC   = RC_WAIT[11:0] - 12'h001;
  localparam [11:0] SLOW_LAST = LRC_WAIT[11:0] - 12'h001;
  localparam [11:0] LRC_LAST  = LRC_DIV[11:0] - 12'h001;

  assign globalIrqEnable = cfgBits[`OMWC_CFG_GIE_BIT];
  assign oscIsCrystal    = cfgBits[`OMWC_CFG_XTAL_BIT];
  assign watchdogAlways  = cfgBits[`OMWC_CFG_WDALL_BIT];
  assign stopReq         = powerCtl[`OMWC_PCTL_STOP_BIT];
  assign idleReq         = powerCtl[`OMWC_PCTL_IDLE_BIT];

  // Zero-wait slave; unmapped access answers with an error
  assign pready  = 1'b1;
  assign addrHit = (paddr == `OMWC_PCTL_ADDR) ||
                   (paddr == `OMWC_WAKE_EN_ADDR) ||
                   (paddr == `OMWC_CFG_ADDR) ||
                   (paddr == `OMWC_STAT_ADDR);
  assign pslverr = psel & penable & ~addrHit;
  assign wrEn    = psel & penable & pwrite & addrHit;
  assign rdSetup = psel & ~penable & ~pwrite;

  // Wake pins: the controller clock is the always-on regulator clock,
  // so a change is captured in stop and only read after two flops
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      firstMeta  <= 8'h00;
      firstSync  <= 8'h00;
      secondMeta <= 8'h00;
      secondSync <= 8'h00;
    end
    else
    begin
      firstMeta  <= firstWakePort;
      firstSync  <= firstMeta;
      secondMeta <= secondWakePort;
      secondSync <= secondMeta;
    end
  end

  // Previous level; compare armed only once the sync chain is full,
  // so a pin already high at reset gives no false change
  reg [2:0] arm;
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      arm        <= 3'h0;
      firstPrev  <= 8'h00;
      secondPrev <= 8'h00;
    end
    else
    begin
      arm        <= {arm[1:0], 1'b1};
      firstPrev  <= firstSync;
      secondPrev <= secondSync;
    end
  end

  // Either edge counts; second port gated per pin
  assign firstChange  = arm[2] ? (firstSync ^ firstPrev) : 8'h00;
  assign secondChange = arm[2] ? (secondSync ^ secondPrev) : 8'h00;
  assign pinWake = (|firstChange) |
                   (|(secondChange & wakeEnable));

  // Interrupt request needs flag, source enable and global enable
  assign irqLive = irqFlags & irqSourceEnable &
                   {IRQ_COUNT{globalIrqEnable}};
  assign irqWake = |irqLive;

  // Slow RC tick divider; held at zero with no tick while the slow RC is stopped
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      lrcDivCount <= 12'h000;
      lrcTick     <= 1'b0;
    end
    else if (!slowOscEnable)
    begin
      lrcDivCount <= 12'h000;
      lrcTick     <= 1'b0;
    end
    else if (lrcDivCount == LRC_LAST)
    begin
      lrcDivCount <= 12'h000;
      lrcTick     <= 1'b1;
    end
    else
    begin
      lrcDivCount <= lrcDivCount + 12'h001;
      lrcTick     <= 1'b0;
    end
  end

  // Mode sequencer; only three resting states, the rest is settling
  always @*
  begin
    next_state       = state;
    next_settleCount = settleCount;
    hwClearStop      = 1'b0;
    hwClearIdle      = 1'b0;
    case (state)
      `OMWC_ST_NORMAL:
      begin
        if (stopReq)
        begin
          next_state = `OMWC_ST_STOP;
        end
        else if (idleReq)
        begin
          next_state = `OMWC_ST_IDLE;
        end
      end
      `OMWC_ST_IDLE:
      begin
        if (pinWake || irqWake)
        begin
          next_state  = `OMWC_ST_NORMAL;
          hwClearIdle = 1'b1;
        end
      end
      `OMWC_ST_STOP:
      begin
        // Interrupts are ignored here on purpose
        if (pinWake)
        begin
          next_state       = `OMWC_ST_SETTLE_H;
          next_settleCount = oscIsCrystal ? FAST_XTAL
                                          : FAST_RC;
        end
      end
      `OMWC_ST_SETTLE_H:
      begin
        // Fast oscillator counted at the controller clock rate
        if (settleCount == 12'h000)
        begin
          next_state       = `OMWC_ST_SETTLE_L;
          next_settleCount = SLOW_LAST;
        end
        else
        begin
          next_settleCount = settleCount - 12'h001;
        end
      end
      `OMWC_ST_SETTLE_L:
      begin
        if (lrcTick)
        begin
          if (settleCount == 12'h000)
          begin
            next_state  = `OMWC_ST_NORMAL;
            hwClearStop = 1'b1;
          end
          else
          begin
            next_settleCount = settleCount - 12'h001;
          end
        end
      end
      default:
      begin
        next_state = `OMWC_ST_NORMAL;
      end
    endcase
  end

  // State register; reset lands in normal
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      state       <= `OMWC_ST_NORMAL;
      settleCount <= 12'h000;
      lastWake    <= 2'b00;
    end
    else
    begin
      state       <= next_state;
      settleCount <= next_settleCount;
      if ((state == `OMWC_ST_IDLE || state == `OMWC_ST_STOP) &&
          next_state != state)
      begin
        lastWake <= {irqWake & ~pinWake, pinWake};
      end
    end
  end

  // Software registers; a write in the clearing cycle wins, and
  // nothing here is touched by stop, so contents are kept
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      powerCtl   <= `OMWC_PCTL_RESET;
      wakeEnable <= `OMWC_WAKE_EN_RESET;
      cfgBits    <= `OMWC_CFG_RESET;
    end
    else
    begin
      if (hwClearStop)
      begin
        powerCtl[`OMWC_PCTL_STOP_BIT] <= 1'b0;
      end
      if (hwClearIdle)
      begin
        powerCtl[`OMWC_PCTL_IDLE_BIT] <= 1'b0;
      end
      if (wrEn && paddr == `OMWC_PCTL_ADDR)
      begin
        powerCtl <= pwdata[3:0];
      end
      if (wrEn && paddr == `OMWC_WAKE_EN_ADDR)
      begin
        wakeEnable <= pwdata[7:0];
      end
      if (wrEn && paddr == `OMWC_CFG_ADDR)
      begin
        cfgBits <= pwdata[2:0];
      end
    end
  end

  // Read data captured in the setup cycle
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (rdSetup)
    begin
      case (paddr)
        `OMWC_PCTL_ADDR:    prdata <= {28'h0000000, powerCtl};
        `OMWC_WAKE_EN_ADDR: prdata <= {24'h000000, wakeEnable};
        `OMWC_CFG_ADDR:     prdata <= {29'h0, cfgBits};
        `OMWC_STAT_ADDR:    prdata <= {27'h0000000, lastWake, state};
        default:            prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Clock and interrupt gating per mode, registered for clean edges
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      fastOscEnable     <= 1'b1;
      slowOscEnable     <= 1'b1;
      cpuClockEnable    <= 1'b1;
      periphClockEnable <= 1'b1;
      analogKeepEnable  <= 1'b1;
      irqRequest        <= {IRQ_COUNT{1'b0}};
      xramHighZero      <= 1'b1;
    end
    else
    begin
      analogKeepEnable <= 1'b1;
      xramHighZero     <= powerCtl[`OMWC_PCTL_P2SEL_BIT];
      case (next_state)
        `OMWC_ST_NORMAL:
        begin
          fastOscEnable     <= 1'b1;
          slowOscEnable     <= 1'b1;
          cpuClockEnable    <= 1'b1;
          periphClockEnable <= 1'b1;
          irqRequest        <= irqLive;
        end
        `OMWC_ST_IDLE:
        begin
          fastOscEnable     <= 1'b1;
          slowOscEnable     <= 1'b1;
          cpuClockEnable    <= 1'b0;
          periphClockEnable <= 1'b1;
          irqRequest        <= irqLive;
        end
        `OMWC_ST_STOP:
        begin
          fastOscEnable     <= 1'b0;
          slowOscEnable     <= watchdogAlways;
          cpuClockEnable    <= 1'b0;
          periphClockEnable <= 1'b0;
          irqRequest        <= {IRQ_COUNT{1'b0}};
        end
        default:
        begin
          // Settling: oscillators up, everything else still held
          fastOscEnable     <= 1'b1;
          slowOscEnable     <= 1'b1;
          cpuClockEnable    <= 1'b0;
          periphClockEnable <= 1'b0;
          irqRequest        <= {IRQ_COUNT{1'b0}};
        end
      endcase
    end
  end

endmodule // omwc_mode_ctrl

`default_nettype wire

// file: inc/omwc_regs.vh
`ifndef OMWC_REGS_VH
`define OMWC_REGS_VH

// Register indices as printed; byte address is four times the index
`define OMWC_PCTL_IDX        8'h87
`define OMWC_WAKE_EN_IDX     8'h91
`define OMWC_CFG_IDX         8'hA0
`define OMWC_STAT_IDX        8'hA1
`define OMWC_PCTL_ADDR       12'h21C
`define OMWC_WAKE_EN_ADDR    12'h244
`define OMWC_CFG_ADDR        12'h280
`define OMWC_STAT_ADDR       12'h284

// Power control register fields
`define OMWC_PCTL_IDLE_BIT   0
`define OMWC_PCTL_STOP_BIT   1
`define OMWC_PCTL_GF0_BIT    2
`define OMWC_PCTL_P2SEL_BIT  3
`define OMWC_PCTL_RESET      4'h8

// Configuration register fields
`define OMWC_CFG_GIE_BIT     0
`define OMWC_CFG_XTAL_BIT    1
`define OMWC_CFG_WDALL_BIT   2
`define OMWC_CFG_RESET       3'h0

`define OMWC_WAKE_EN_RESET   8'h00

// Settling waits in oscillator clocks
`define OMWC_XTAL_WAIT       2048
`define OMWC_RC_WAIT         64
`define OMWC_LRC_WAIT        5

// Slow RC model: 16 kHz from the 50 MHz clock
`define OMWC_SYS_CLK_HZ      50000000
`define OMWC_LRC_HZ          16000

// Operating states
`define OMWC_ST_NORMAL       3'h0
`define OMWC_ST_IDLE         3'h1
`define OMWC_ST_STOP         3'h2
`define OMWC_ST_SETTLE_H     3'h3
`define OMWC_ST_SETTLE_L     3'h4

`endif

// file: test/omwc_irq_src.sv
`timescale 1ns/1ns
`default_nettype none

module omwc_irq_src #(
  parameter int N = 15
) (
  input  wire logic         sys_clk,
  input  wire logic         reset,
  input  wire logic         fire,
  input  wire logic         clear,
  input  wire logic [3:0]   src,
  output var  logic [N-1:0] irqFlags
);
  // Flags stay up until software clears them, so wakes see a live request
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      irqFlags <= '0;
    else if (clear)
      irqFlags <= '0;
    else if (fire)
      irqFlags[src] <= 1'h1;
  end
endmodule // omwc_irq_src

`default_nettype wire

// file: test/omwc_mode_ctrl_sva.sv
`timescale 1ns/1ns
`default_nettype none
`include "omwc_regs.vh"

module omwc_mode_ctrl_sva #(
  parameter integer IRQ_COUNT = 15
) (
  input wire logic                 sys_clk,
  input wire logic                 reset,
  input wire logic [11:0]          paddr,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [31:0]          pwdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic [IRQ_COUNT-1:0] irqFlags,
  input wire logic [IRQ_COUNT-1:0] irqSourceEnable,
  input wire logic [IRQ_COUNT-1:0] irqRequest,
  input wire logic                 fastOscEnable,
  input wire logic                 slowOscEnable,
  input wire logic                 cpuClockEnable,
  input wire logic                 periphClockEnable,
  input wire logic                 analogKeepEnable
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // Completed software write to power control
  sequence pctlWrite;
    psel && penable && pwrite && paddr == `OMWC_PCTL_ADDR;
  endsequence

  // Gating relations between the mode outputs
  chk_cpu_periph:
    assert property (cpuClockEnable |-> periphClockEnable)
    else $error("cpu clocked without peripherals");
  chk_stop_gates:
    assert property (!fastOscEnable |-> !cpuClockEnable && !periphClockEnable)
    else $error("clocks run with fast osc off");
  chk_slow_osc:
    assert property (fastOscEnable |-> slowOscEnable)
    else $error("slow osc off outside stop");
  chk_analog_on:
    assert property (analogKeepEnable)
    else $error("analog keep dropped");
  chk_irq_stop:
    assert property (!periphClockEnable |-> irqRequest == '0)
    else $error("interrupt raised in stop");
  chk_irq_gate:
    assert property ((irqRequest & ~$past(irqFlags & irqSourceEnable)) == '0)
    else $error("interrupt without flag and enable");
  chk_reset_normal:
    assert property ($fell(reset) |-> cpuClockEnable && fastOscEnable)
    else $error("not normal after reset");
  // Mode entry takes effect within a few edges of the write
  chk_stop_entry:
    assert property (pctlWrite ##0 pwdata[1] |->
      ##[1:4] (!fastOscEnable && !cpuClockEnable))
    else $error("stop not entered");
  chk_idle_entry:
    assert property (pctlWrite ##0 (pwdata[0] && !pwdata[1]) |->
      ##[1:4] (!cpuClockEnable && periphClockEnable))
    else $error("idle not entered");
  chk_err_access:
    assert property (pslverr |-> psel && penable && pready)
    else $error("error outside access phase");
endmodule // omwc_mode_ctrl_sva

bind omwc_mode_ctrl omwc_mode_ctrl_sva #(.IRQ_COUNT(IRQ_COUNT)) u_chk (
  .sys_clk, .reset, .paddr, .psel, .penable, .pwrite, .pwdata, .pready,
  .pslverr, .irqFlags, .irqSourceEnable, .irqRequest, .fastOscEnable,
  .slowOscEnable, .cpuClockEnable, .periphClockEnable, .analogKeepEnable);

`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "omwc_regs.vh"
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin failCount++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end

module tb_top;
  localparam int LD = 4;
  localparam int XW = 16;
  localparam int RW = 64;
  logic        sys_clk = 0;
  logic        reset = 1;
  logic [11:0] paddr = '0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  firstWakePort = '0;
  logic [7:0]  secondWakePort = '0;
  logic [14:0] irqFlags;
  logic [14:0] irqSourceEnable = '0;
  logic [14:0] irqRequest;
  logic        fastOscEnable;
  logic        slowOscEnable;
  logic        cpuClockEnable;
  logic        periphClockEnable;
  logic        fire = 0;
  logic        clear = 0;
  logic [3:0]  src = 4'h5;
  logic [31:0] rd;
  logic        er;
  logic        xramHighZero;
  int          failCount = 0;
  int          nTests = 0;
  int          c;

  // Shortened settling counts keep the run brief
  omwc_mode_ctrl #(.XTAL_WAIT(XW), .LRC_DIV(LD)) i_omwc_mode_ctrl (
    .sys_clk, .reset, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .firstWakePort, .secondWakePort, .irqFlags,
    .irqSourceEnable, .irqRequest, .fastOscEnable, .slowOscEnable,
    .cpuClockEnable, .periphClockEnable, .analogKeepEnable(),
    .xramHighZero);
  omwc_irq_src i_omwc_irq_src (
    .sys_clk, .reset, .fire, .clear, .src, .irqFlags);

  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;

  task stopTest;
    if (failCount == 0 && nTests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // One APB transfer; waits for pready under a bound
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge sys_clk);
      if (pready === 1'h1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    if (n == 20)
    begin
      failCount++;
      stopTest();
    end
  endtask

  task rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    `CHK(rd, e)
  endtask

  // Fast, slow, cpu, peripheral enables
  task outs(input logic [3:0] e);
    @(negedge sys_clk);
    `CHK({fastOscEnable, slowOscEnable, cpuClockEnable, periphClockEnable}, e)
  endtask

  // Counts cycles until the cpu is clocked again
  task wait_cpu;
    for (c = 0; c < 2000; c++)
    begin
      @(negedge sys_clk);
      if (cpuClockEnable === 1'h1) break;
    end
    if (c == 2000)
    begin
      failCount++;
      stopTest();
    end
  endtask

  task pulse_irq(input logic kill);
    @(posedge sys_clk);
    fire <= !kill;
    clear <= kill;
    @(posedge sys_clk);
    fire <= 0;
    clear <= 0;
  endtask

  task t_reset;
    outs(4'hF);
    `CHK(xramHighZero, 1'h1)
    rdchk(`OMWC_PCTL_ADDR, 32'h8);
    rdchk(`OMWC_WAKE_EN_ADDR, 32'h0);
    apb(1, 12'hFFC, 32'h5);
    `CHK({er, rd}, {1'h1, 32'h0})
    // Flag and address-byte bits only: no mode change
    apb(1, `OMWC_PCTL_ADDR, 32'h4);
    rdchk(`OMWC_PCTL_ADDR, 32'h4);
    outs(4'hF);
    `CHK(xramHighZero, 1'h0)
    apb(1, `OMWC_PCTL_ADDR, 32'h8);
  endtask

  task t_idle;
    apb(1, `OMWC_CFG_ADDR, 32'h1);
    irqSourceEnable <= 15'h0020;
    apb(1, `OMWC_PCTL_ADDR, 32'h9);
    repeat (4) @(posedge sys_clk);
    outs(4'hD);
    rdchk(`OMWC_STAT_ADDR, 32'h1);
    pulse_irq(0);
    wait_cpu();
    `CHK(irqRequest[5], 1'h1)
    rdchk(`OMWC_PCTL_ADDR, 32'h8);
    rdchk(`OMWC_STAT_ADDR, 32'h10);
  endtask

  // Disabled second-port pin and enabled interrupt must not end stop
  task t_stop_rc;
    pulse_irq(1);
    apb(1, `OMWC_PCTL_ADDR, 32'hA);
    repeat (4) @(posedge sys_clk);
    outs(4'h0);
    rdchk(`OMWC_STAT_ADDR, 32'h12);
    pulse_irq(0);
    secondWakePort[2] <= 1;
    repeat (20) @(posedge sys_clk);
    outs(4'h0);
    `CHK(irqRequest, 15'h0)
    @(posedge sys_clk);
    firstWakePort[3] <= 1;
    wait_cpu();
    `CHK(c inside {[RW + 4 * LD:RW + 5 * LD + 8]}, 1'h1)
    rdchk(`OMWC_PCTL_ADDR, 32'h8);
    rdchk(`OMWC_STAT_ADDR, 32'h8);
  endtask

  task t_stop_xtal;
    pulse_irq(1);
    apb(1, `OMWC_WAKE_EN_ADDR, 32'h4);
    apb(1, `OMWC_CFG_ADDR, 32'h6);
    apb(1, `OMWC_PCTL_ADDR, 32'hA);
    repeat (4) @(posedge sys_clk);
    outs(4'h4);
    @(posedge sys_clk);
    secondWakePort[2] <= 0;
    wait_cpu();
    `CHK(c inside {[XW + 4 * LD:XW + 5 * LD + 8]}, 1'h1)
    rdchk(`OMWC_WAKE_EN_ADDR, 32'h4);
    rdchk(`OMWC_CFG_ADDR, 32'h6);
    // Global enable is off here, so a live flag raises nothing
    pulse_irq(0);
    repeat (2) @(negedge sys_clk);
    `CHK(irqRequest, 15'h0)
  endtask

  // Both request bits set: stop wins, and a reset ends it with no pin change
  task t_reset_stop;
    apb(1, `OMWC_PCTL_ADDR, 32'hB);
    repeat (4) @(posedge sys_clk);
    outs(4'h4);
    @(posedge sys_clk);
    reset <= 1;
    repeat (2) @(posedge sys_clk);
    reset <= 0;
    outs(4'hF);
    rdchk(`OMWC_PCTL_ADDR, 32'h8);
    rdchk(`OMWC_CFG_ADDR, 32'h0);
    rdchk(`OMWC_WAKE_EN_ADDR, 32'h0);
    outs(4'hF);
  endtask

  // Main sequence
  initial
  begin
    repeat (10) @(posedge sys_clk);
    reset <= 0;
    t_reset();
    t_idle();
    t_stop_rc();
    t_stop_xtal();
    t_reset_stop();
    stopTest();
  end
endmodule // tb_top

`default_nettype wire
